/* File: design/hsttu_top.sv */
// Hint, sleep, exception-trigger and target-query execution unit.
//
// Function
// RULE1 - NOP may be folded without using cycles
// RULE2 - Send event pulses outgoing event line
// RULE3 - Send event sets local event register
// RULE4 - Wait for event sleeps until wake cause
// RULE5 - Set event register: clear, finish at once
// RULE6 - Wait for interrupt sleeps until wake cause
// RULE7 - Supervisor call raises its exception
// RULE8 - Supervisor call immediate never acted upon
// RULE9 - Permanently undefined raises usage fault
// RULE10 - Gateway marker is only valid entry point
// RULE11 - Alternate queries undefined from Non-secure
// RULE12 - Unprivileged query uses unprivileged permissions
// RULE13 - Bits 7:0 protection region, else zero
// RULE14 - Bits 15:8 attribution region, else zero
// RULE15 - Bits 16, 17 are region valid flags
// RULE16 - Bits 18, 19 read and read-write
// RULE17 - Bits 20, 21 permissions without secure
// RULE18 - Bit 22 marks a Secure location
// RULE19 - Bits 31:23 implementation region and valid
// RULE20 - Protection region invalid in four cases
// RULE21 - Permissions zero on multi-hit or unprivileged
// RULE22 - Yield accepted as hint, optional swap
// RULE23 - Event register resets to zero
// RULE24 - Condition flags never written
module hsttu_top
  import hsttu_pkg::*;
(
  // Clock, reset and freeze.
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Instruction issue.
  input wire logic issue_valid,
  input wire hsttu_op_e issue_op,
  output logic issue_ready,
  input wire logic cpu_secure,
  input wire logic cpu_priv,
  input wire logic ns_to_s_branch,
  output logic done,
  output logic flags_we,
  // Exception triggers.
  output logic svc_req,
  output logic undef_req,
  output logic gateway_ok,
  output logic gateway_fault,
  output logic yield_swap,
  // Events and sleep.
  input wire logic event_in,
  output logic event_out,
  input wire hsttu_wake_s wake,
  output logic sleeping,
  // Target query towards protection and attribution units.
  output logic tq_unpriv,
  output logic tq_nonsecure,
  input wire hsttu_prot_s prot,
  input wire hsttu_attr_s attr,
  output logic [31:0] tt_result
);

  typedef struct packed {
    logic ev_s1;
    logic ev_s2;
    logic ev_s3;
    logic event_reg;
    hsttu_slp_e slp;
    hsttu_ctrl_s ctrl;
    logic done;
    logic svc;
    logic undef;
    logic gw_ok;
    logic gw_fault;
    logic ev_out;
    logic yld;
    hsttu_tt_s tt;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } hsttu_st_s;

  hsttu_st_s st_r;
  hsttu_st_s st_nxt;

  logic take;
  logic ev_rise;
  logic wake_wfe;
  logic wake_wfi;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic wr_go;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic alt_q;
  logic unp_q;
  logic plain_q;
  logic is_tt;
  logic perm_block;
  logic mreg_ok;
  logic sec_view;
  hsttu_tt_s tt_calc;

  // Readies drop while frozen so that no beat is taken unseen.
  assign s_axi_awready = clk_en & ~st_r.aw_got & ~st_r.bvalid;
  assign s_axi_wready = clk_en & ~st_r.w_got & ~st_r.bvalid;
  assign s_axi_arready = clk_en & ~st_r.rvalid;
  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire = s_axi_wvalid & s_axi_wready;
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign wr_go = (st_r.aw_got | aw_fire) & (st_r.w_got | w_fire);
  assign wr_addr = st_r.aw_got ? st_r.awaddr : s_axi_awaddr;
  assign wr_data = st_r.w_got ? st_r.wdata : s_axi_wdata;
  assign wr_strb = st_r.w_got ? st_r.wstrb : s_axi_wstrb;

  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;

  assign issue_ready = clk_en & (st_r.slp == SLP_RUN);
  assign take = issue_valid & issue_ready;
  assign sleeping = st_r.slp != SLP_RUN;
  assign done = st_r.done;
  assign svc_req = st_r.svc;
  assign undef_req = st_r.undef;
  assign gateway_ok = st_r.gw_ok;
  assign gateway_fault = st_r.gw_fault;
  assign event_out = st_r.ev_out;
  assign yield_swap = st_r.yld;
  assign tt_result = st_r.tt;
  // No instruction here writes the condition flags.
  assign flags_we = 1'b0; // RULE24

  // Only the second and third stages of the event synchroniser are compared.
  assign ev_rise = st_r.ev_s2 & ~st_r.ev_s3;

  assign wake_wfe = wake.exc_unmasked | (wake.exc_new_pending & st_r.ctrl.wake_on_pending)
                    | (wake.debug_req & st_r.ctrl.dbg_en) | ev_rise; // RULE4
  assign wake_wfi = wake.irq_taken | wake.irq_pend_masked
                    | (wake.debug_req & st_r.ctrl.dbg_en); // RULE6

  // Query decode, driven towards the protection unit in the issue cycle.
  assign is_tt = (issue_op == OP_TT) | (issue_op == OP_TTT)
                 | (issue_op == OP_TTA) | (issue_op == OP_TARGET_QUERY_ALT_UNPRIV);
  assign alt_q = (issue_op == OP_TTA) | (issue_op == OP_TARGET_QUERY_ALT_UNPRIV);
  assign unp_q = (issue_op == OP_TTT) | (issue_op == OP_TARGET_QUERY_ALT_UNPRIV);
  assign plain_q = (issue_op == OP_TT) | (issue_op == OP_TTT);
  assign tq_unpriv = is_tt & (unp_q | ~cpu_priv); // RULE12
  assign tq_nonsecure = is_tt & (alt_q | ~cpu_secure);

  assign perm_block = prot.multi | (plain_q & ~cpu_priv); // RULE21
  assign mreg_ok = prot.mpu_on & prot.hit & ~prot.multi & ~(plain_q & ~cpu_priv); // RULE20
  // Attribution fields only mean something from Secure state with the extension present.
  assign sec_view = st_r.ctrl.sec_ext & cpu_secure;

  always_comb begin
    tt_calc = '0;
    tt_calc.protection_region_valid = mreg_ok; // RULE15
    tt_calc.protection_region_number = mreg_ok ? prot.region : 8'h00; // RULE13
    tt_calc.attribution_region_valid = sec_view & attr.sau_valid; // RULE15
    tt_calc.attribution_region_number = (sec_view & attr.sau_valid) ?
                                        attr.sau_region : 8'h00; // RULE14
    tt_calc.read_ok = prot.rd_ok & ~perm_block; // RULE16
    tt_calc.readwrite_ok = prot.rd_ok & prot.rw_ok & ~perm_block; // RULE16
    tt_calc.secure = sec_view & attr.secure_loc; // RULE18
    tt_calc.nonsecure_read_ok = tt_calc.read_ok & ~tt_calc.secure; // RULE17
    tt_calc.nonsecure_readwrite_ok = tt_calc.readwrite_ok & ~tt_calc.secure; // RULE17
    tt_calc.impl_attr_region_valid = sec_view & attr.impl_defined_attribution_unit_valid & ~attr.impl_defined_attribution_unit_exempt; // RULE19
    tt_calc.impl_attr_region_number = tt_calc.impl_attr_region_valid ?
                                      attr.impl_defined_attribution_unit_region : 8'h00; // RULE19
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.ev_s1 = event_in;
    st_nxt.ev_s2 = st_r.ev_s1;
    st_nxt.ev_s3 = st_r.ev_s2;
    st_nxt.done = 1'b0;
    st_nxt.svc = 1'b0;
    st_nxt.undef = 1'b0;
    st_nxt.gw_ok = 1'b0;
    st_nxt.gw_fault = 1'b0;
    st_nxt.ev_out = 1'b0;
    st_nxt.yld = 1'b0;

    unique case (st_r.slp)
      SLP_RUN: begin
        if (take) begin
          st_nxt.done = 1'b1;
          // A branch from Non-secure code must land on the gateway marker.
          if (ns_to_s_branch) begin
            st_nxt.gw_ok = issue_op == OP_SG; // RULE10
            st_nxt.gw_fault = issue_op != OP_SG; // RULE10
          end
          unique case (issue_op)
            OP_NOP: begin
              st_nxt.done = ~st_r.ctrl.nop_fold; // RULE1
            end
            OP_YIELD: begin
              st_nxt.yld = st_r.ctrl.yield_swap; // RULE22
            end
            OP_SEV: begin
              st_nxt.ev_out = 1'b1; // RULE2
              st_nxt.event_reg = 1'b1; // RULE3
            end
            OP_WFE: begin
              if (st_r.event_reg) begin
                st_nxt.event_reg = 1'b0; // RULE5
              end else begin
                st_nxt.slp = SLP_WFE; // RULE4
                st_nxt.done = 1'b0;
              end
            end
            OP_WFI: begin
              st_nxt.slp = SLP_WFI; // RULE6
              st_nxt.done = 1'b0;
            end
            OP_SVC: begin
              // The immediate is not even carried here; the handler fetches it.
              st_nxt.svc = 1'b1; // RULE7 RULE8
            end
            OP_UDF: begin
              st_nxt.undef = 1'b1; // RULE9
            end
            OP_SG: begin
            end
            OP_TT, OP_TTT, OP_TTA, OP_TARGET_QUERY_ALT_UNPRIV: begin
              if (alt_q & ~cpu_secure) begin
                st_nxt.undef = 1'b1; // RULE11
              end else begin
                st_nxt.tt = tt_calc;
              end
            end
            default: begin
              st_nxt.undef = 1'b1;
            end
          endcase
        end
      end
      SLP_WFE: begin
        if (wake_wfe) begin
          st_nxt.slp = SLP_RUN; // RULE4
          st_nxt.done = 1'b1;
        end
      end
      SLP_WFI: begin
        if (wake_wfi) begin
          st_nxt.slp = SLP_RUN; // RULE6
          st_nxt.done = 1'b1;
        end
      end
      default: begin
        st_nxt.slp = SLP_RUN;
      end
    endcase

    // An incoming event latches last so it outlives a same-cycle clear.
    if (ev_rise & (st_r.slp != SLP_WFE)) begin
      st_nxt.event_reg = 1'b1;
    end

    if (aw_fire) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (w_fire) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (wr_go) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      if (wr_addr == ADDR_CTRL) begin
        if (wr_strb[0]) begin
          st_nxt.ctrl = hsttu_ctrl_s'(wr_data[CTRL_W-1:0]);
        end
      end else if ((wr_addr != ADDR_STATUS) && (wr_addr != ADDR_TTRES)) begin
        st_nxt.bresp = RESP_SLVERR;
      end
    end
    if (st_r.bvalid & s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    if (ar_fire) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      st_nxt.rdata = DATA_ZERO;
      unique case (s_axi_araddr)
        ADDR_CTRL: st_nxt.rdata[CTRL_W-1:0] = st_r.ctrl;
        ADDR_STATUS: st_nxt.rdata[2:0] = {st_r.slp == SLP_WFI, st_r.slp != SLP_RUN,
                                          st_r.event_reg};
        ADDR_TTRES: st_nxt.rdata = st_r.tt;
        default: st_nxt.rresp = RESP_SLVERR;
      endcase
    end else if (st_r.rvalid & s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
      st_r.event_reg <= EVENT_RST; // RULE23
      st_r.slp <= SLP_RUN;
      st_r.ctrl <= CTRL_RST;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

endmodule : hsttu_top

/* File: inc/hsttu_pkg.sv */
// Shared constants and carrier types of the hint, sleep and target-query unit.
package hsttu_pkg;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TTRES = 8'h08;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  typedef enum logic [3:0] {
    OP_NOP, OP_YIELD, OP_SEV, OP_WFE, OP_WFI, OP_SVC, OP_UDF, OP_SG,
    OP_TT, OP_TTT, OP_TTA, OP_TARGET_QUERY_ALT_UNPRIV
  } hsttu_op_e;

  typedef enum logic [1:0] {SLP_RUN, SLP_WFE, SLP_WFI} hsttu_slp_e;

  // Control register, bit 0 is wake_on_pending.
  typedef struct packed {
    logic nop_fold;
    logic yield_swap;
    logic sec_ext;
    logic dbg_en;
    logic wake_on_pending;
  } hsttu_ctrl_s;

  localparam int CTRL_W = $bits(hsttu_ctrl_s);
  localparam hsttu_ctrl_s CTRL_RST = hsttu_ctrl_s'(5'h04);
  localparam logic EVENT_RST = 1'b0;

  typedef struct packed {
    logic mpu_on;
    logic hit;
    logic multi;
    logic [7:0] region;
    logic rd_ok;
    logic rw_ok;
  } hsttu_prot_s;

  typedef struct packed {
    logic sau_valid;
    logic [7:0] sau_region;
    logic secure_loc;
    logic impl_defined_attribution_unit_valid;
    logic impl_defined_attribution_unit_exempt;
    logic [7:0] impl_defined_attribution_unit_region;
  } hsttu_attr_s;

  typedef struct packed {
    logic exc_unmasked;
    logic exc_new_pending;
    logic irq_taken;
    logic irq_pend_masked;
    logic debug_req;
  } hsttu_wake_s;

  typedef struct packed {
    logic [7:0] impl_attr_region_number;
    logic impl_attr_region_valid;
    logic secure;
    logic nonsecure_readwrite_ok;
    logic nonsecure_read_ok;
    logic readwrite_ok;
    logic read_ok;
    logic attribution_region_valid;
    logic protection_region_valid;
    logic [7:0] attribution_region_number;
    logic [7:0] protection_region_number;
  } hsttu_tt_s;

endpackage : hsttu_pkg

/* File: sim/hsttu_properties.sv */
// Concurrent checks on the ports of the hint, sleep and target-query unit.
module hsttu_props
  import hsttu_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic arst_n,
  // Issue side.
  input wire logic issue_valid,
  input wire hsttu_op_e issue_op,
  input wire logic issue_ready,
  input wire logic cpu_secure,
  input wire logic ns_to_s_branch,
  input wire logic done,
  input wire logic flags_we,
  // Triggers, sleep and result.
  input wire logic svc_req,
  input wire logic undef_req,
  input wire logic gateway_ok,
  input wire logic gateway_fault,
  input wire logic event_out,
  input wire logic sleeping,
  input wire hsttu_wake_s wake,
  input wire logic [31:0] tt_result
);
  logic tk;
  logic wfi_wake;
  assign tk = issue_valid && issue_ready;
  assign wfi_wake = wake.irq_taken || wake.irq_pend_masked || wake.debug_req;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_sev_pulse: assert property (tk && issue_op == OP_SEV |=> event_out && done)
    else $error("send event gave no pulse");
  a_flags_kept: assert property (flags_we == 1'h0)
    else $error("flags written");
  a_svc_raise: assert property (tk && issue_op == OP_SVC |=> svc_req && !undef_req)
    else $error("supervisor call not raised");
  a_udf_raise: assert property (tk && issue_op == OP_UDF |=> undef_req && !svc_req)
    else $error("undefined fault not raised");
  a_alt_undef: assert property (tk && (issue_op == OP_TTA || issue_op == OP_TARGET_QUERY_ALT_UNPRIV) && !cpu_secure
    |=> undef_req && $stable(tt_result))
    else $error("alternate query from non-secure not refused");
  a_gate_fault: assert property (tk && ns_to_s_branch && issue_op != OP_SG
    |=> gateway_fault && !gateway_ok)
    else $error("bad gateway landing accepted");
  a_sleep_hold: assert property (sleeping |-> !issue_ready)
    else $error("issue accepted while asleep");
  a_wfi_sleep: assert property (tk && issue_op == OP_WFI && !wfi_wake |=> sleeping)
    else $error("wait for interrupt did not sleep");
  a_region_zero: assert property (!tt_result[16] |-> tt_result[7:0] == 8'h00)
    else $error("invalid region number not zero");
  a_ns_perms: assert property (tt_result[21:20] == (tt_result[19:18] & {2{!tt_result[22]}}))
    else $error("non-secure permission bits wrong");
  c_wfe: cover property (tk && issue_op == OP_WFE);
  c_tt: cover property (tk && issue_op == OP_TT);
  c_wake: cover property ($fell(sleeping));
endmodule : hsttu_props

/* File: sim/hsttu_event_peer.sv */
// Model of another processor on the shared event line.
module hsttu_event_peer (
  // Clock and reset.
  input wire logic mclk,
  input wire logic arst_n,
  // Event lines.
  input wire logic fire,
  input wire logic event_out,
  output logic event_in,
  output int sev_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] hold_r;
  // Held four cycles so the level survives the receiver's three-flop synchroniser.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hold_r <= 3'h0;
      sev_seen <= 0;
    end else begin
      hold_r <= fire ? 3'h4 : hold_r - 3'(hold_r != 3'h0);
      sev_seen <= sev_seen + int'(event_out);
    end
  end
  assign event_in = hold_r != 3'h0;
endmodule : hsttu_event_peer

/* File: sim/test_hint_sleep_target_test_unit.sv */
// Self-checking bench of the hint, sleep and target-query unit.
`define CHK(n, e, a) begin \
  total_checks++; \
  if ((a) !== (e)) begin \
    fails++; \
    $display("Error %s exp %h got %h", n, e, a); \
  end \
end
module test_hint_sleep_target_test_unit
  import hsttu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, arst_n = 0, clk_en = 1, fire = 0, tqu, tqn;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, issue_valid = 0, cpu_secure = 0, cpu_priv = 0, ns_to_s_branch = 0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, tt_result, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  hsttu_op_e issue_op = OP_NOP;
  hsttu_wake_s wake = '0;
  hsttu_prot_s prot = '0;
  hsttu_attr_s attr = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, issue_ready;
  logic done, flags_we, svc_req, undef_req, gateway_ok, gateway_fault, yield_swap;
  logic event_in, event_out, sleeping, tq_unpriv, tq_nonsecure;
  int fails = 0, total_checks = 0, sev_seen;
  hsttu_top i_dut (.mclk, .arst_n, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .issue_valid, .issue_op, .issue_ready, .cpu_secure,
    .cpu_priv, .ns_to_s_branch, .done, .flags_we, .svc_req, .undef_req, .gateway_ok,
    .gateway_fault, .yield_swap, .event_in, .event_out, .wake, .sleeping, .tq_unpriv,
    .tq_nonsecure, .prot, .attr, .tt_result);
  hsttu_event_peer i_peer (.mclk, .arst_n, .fire, .event_out, .event_in, .sev_seen);
  always #2.5 mclk = ~mclk;
  task automatic finish_test();
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  // Handshakes are judged on settled values before the edge, so a beat is dropped only once taken.
  task automatic axw(logic [7:0] a, logic [31:0] d);
    logic aw_hit, w_hit, b_hit;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge mclk);
      aw_hit = s_axi_awvalid & s_axi_awready;
      w_hit = s_axi_wvalid & s_axi_wready;
      b_hit = s_axi_bvalid === 1'h1;
      if (b_hit) `CHK("bresp", RESP_OKAY, s_axi_bresp)
      @(posedge mclk);
      if (aw_hit) s_axi_awvalid <= 1'h0;
      if (w_hit) s_axi_wvalid <= 1'h0;
    end while (!b_hit);
    s_axi_bready <= 1'h0;
  endtask : axw
  task automatic axr(logic [7:0] a);
    logic ar_hit, r_hit;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge mclk);
      ar_hit = s_axi_arvalid & s_axi_arready;
      r_hit = s_axi_rvalid === 1'h1;
      if (r_hit) begin
        rd = s_axi_rdata;
        rr = s_axi_rresp;
      end
      @(posedge mclk);
      if (ar_hit) s_axi_arvalid <= 1'h0;
    end while (!r_hit);
    s_axi_rready <= 1'h0;
  endtask : axr
  // Ends at the negative edge of the cycle after the taking edge, where pulses stand.
  task automatic issue(hsttu_op_e op, logic sec, logic priv, logic br);
    @(posedge mclk);
    issue_op <= op;
    cpu_secure <= sec;
    cpu_priv <= priv;
    ns_to_s_branch <= br;
    issue_valid <= 1'h1;
    @(posedge mclk);
    tqu = tq_unpriv;
    tqn = tq_nonsecure;
    issue_valid <= 1'h0;
    ns_to_s_branch <= 1'h0;
    @(negedge mclk);
  endtask : issue
  task automatic wait_awake(string n);
    int k;
    k = 0;
    while (sleeping === 1'h1 && k < 20) begin
      @(negedge mclk);
      k++;
    end
    `CHK(n, 1'h0, sleeping)
    @(posedge mclk);
    wake <= '0;
  endtask : wait_awake
  task automatic t_reset();
    axr(ADDR_STATUS);
    `CHK("event_reg", DATA_ZERO, rd)
    `CHK("tt_reset", DATA_ZERO, tt_result)
    axr(8'h40);
    `CHK("bad_addr", RESP_SLVERR, rr)
  endtask : t_reset
  task automatic t_sev();
    issue(OP_SEV, 1'h1, 1'h1, 1'h0);
    `CHK("event_out", 1'h1, event_out)
    axr(ADDR_STATUS);
    `CHK("event_set", 1'h1, rd[0])
    `CHK("peer_seen", 1, sev_seen)
    issue(OP_WFE, 1'h1, 1'h1, 1'h0);
    `CHK("wfe_quick", 1'h1, done)
    `CHK("wfe_run", 1'h0, sleeping)
    axr(ADDR_STATUS);
    `CHK("event_clr", 1'h0, rd[0])
  endtask : t_sev
  task automatic t_wfe();
    issue(OP_WFE, 1'h1, 1'h1, 1'h0);
    `CHK("wfe_block", 1'h0, issue_ready)
    fire <= 1'h1;
    @(posedge mclk);
    fire <= 1'h0;
    wait_awake("event_wake");
    issue(OP_WFE, 1'h1, 1'h1, 1'h0);
    wake.exc_new_pending <= 1'h1;
    repeat (5) @(negedge mclk);
    `CHK("pend_ignored", 1'h1, sleeping)
    axw(ADDR_CTRL, 32'h0000_0005);
    wait_awake("pend_wake");
    issue(OP_WFE, 1'h1, 1'h1, 1'h0);
    `CHK("wfe_sleep", 1'h1, sleeping)
    wake.exc_unmasked <= 1'h1;
    wait_awake("exc_wake");
  endtask : t_wfe
  task automatic t_wfi();
    issue(OP_WFI, 1'h1, 1'h1, 1'h0);
    wake.debug_req <= 1'h1;
    repeat (5) @(negedge mclk);
    `CHK("dbg_off", 1'h1, sleeping)
    wake.irq_pend_masked <= 1'h1;
    wait_awake("irq_wake");
  endtask : t_wfi
  task automatic t_exc();
    issue(OP_SVC, 1'h1, 1'h1, 1'h0);
    `CHK("svc", 1'h1, svc_req)
    issue(OP_UDF, 1'h1, 1'h1, 1'h0);
    `CHK("udf", 1'h1, undef_req)
    issue(OP_SG, 1'h0, 1'h1, 1'h1);
    `CHK("gate_ok", 1'h1, gateway_ok)
    issue(OP_NOP, 1'h0, 1'h1, 1'h1);
    `CHK("gate_bad", 1'h1, gateway_fault)
    issue(OP_YIELD, 1'h1, 1'h1, 1'h0);
    `CHK("yield", 2'h2, {done, yield_swap})
    axw(ADDR_CTRL, 32'h0000_0015);
    issue(OP_NOP, 1'h1, 1'h1, 1'h0);
    `CHK("nop_fold", 1'h0, done)
    axw(ADDR_CTRL, 32'h0000_0005);
    @(posedge mclk);
    clk_en <= 1'h0;
    @(negedge mclk);
    `CHK("frozen", 1'h0, issue_ready)
    @(posedge mclk);
    clk_en <= 1'h1;
  endtask : t_exc
  task automatic t_tt();
    prot <= {1'h1, 1'h1, 1'h0, 8'h05, 1'h1, 1'h1};
    attr <= {1'h1, 8'h03, 1'h1, 1'h1, 1'h0, 8'h09};
    issue(OP_TT, 1'h1, 1'h1, 1'h0);
    `CHK("tt_full", 32'h09CF_0305, tt_result)
    issue(OP_TT, 1'h1, 1'h0, 1'h0);
    `CHK("tt_unpriv", 32'h09C2_0300, tt_result)
    issue(OP_TTT, 1'h1, 1'h1, 1'h0);
    `CHK("ttt_unpriv", 1'h1, tqu)
    prot.multi <= 1'h1;
    attr.impl_defined_attribution_unit_exempt <= 1'h1;
    issue(OP_TT, 1'h1, 1'h1, 1'h0);
    `CHK("tt_multi", 32'h0042_0300, tt_result)
    prot.multi <= 1'h0;
    issue(OP_TT, 1'h0, 1'h1, 1'h0);
    `CHK("tt_ns", 32'h003D_0005, tt_result)
    `CHK("tq_ns", 1'h1, tqn)
    issue(OP_TTA, 1'h0, 1'h1, 1'h0);
    `CHK("tta_ns", 33'h1_003D_0005, {undef_req, tt_result})
  endtask : t_tt
  initial begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'h1;
    t_reset();
    t_sev();
    t_wfe();
    t_wfi();
    t_exc();
    t_tt();
    finish_test();
  end
  initial begin
    #20us;
    fails++;
    finish_test();
  end
endmodule : test_hint_sleep_target_test_unit
bind hsttu_top hsttu_props i_props (.mclk, .arst_n, .issue_valid, .issue_op, .issue_ready,
  .cpu_secure, .ns_to_s_branch, .done, .flags_we, .svc_req, .undef_req, .gateway_ok,
  .gateway_fault, .event_out, .sleeping, .wake, .tt_result);
